/* shared/ssr_pkg.sv */
// Package with register map, field layout and codes of the status bank.
package ssr_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CHIP_REVISION = 8'h00;
  localparam logic [7:0] ADDR_STATUS_FLAG_SET = 8'h01;
  localparam logic [7:0] ADDR_GENERAL_STATUS_ONE = 8'h05;
  localparam logic [7:0] ADDR_GENERAL_FAULT = 8'h38;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_PG_FAULT = 15;
  localparam int BIT_DIM_LIMIT = 14;
  localparam int BIT_RAIL_TIMER = 13;
  localparam int BIT_PARITY = 12;
  localparam int BIT_ADC_ERR = 11;
  localparam int BIT_CSUM_LED = 10;
  localparam int BIT_CSUM_SENSOR = 9;
  localparam int BIT_CSUM_ADC = 8;
  localparam int BIT_WD_TWO = 7;
  localparam int BIT_WD_ONE = 6;
  localparam int BIT_STATE_CHG = 5;
  localparam int BIT_BRIGHT = 4;
  localparam int BIT_RAIL_FAULT = 3;
  localparam int BIT_TEMP_WARN = 2;
  localparam int BIT_TEMP_ERR = 1;
  localparam int BIT_PROJ_LOW = 0;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] GENERAL_RESET = 16'h0000;
  localparam logic [15:0] FAULT_RESET = 16'h0000;
  localparam logic [15:0] UNMAPPED_DATA = 16'h0000;
  // ----------------------------------------------------------------
  // Last reset cause codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SSR_CAUSE_POR = 3'b000,
    SSR_CAUSE_PROJ_LOW = 3'b001,
    SSR_CAUSE_WD_ONE = 3'b010,
    SSR_CAUSE_WD_TWO = 3'b011,
    SSR_CAUSE_OVERTEMP = 3'b100,
    SSR_CAUSE_SW_CYCLE = 3'b101
  } ssr_cause_t;
  localparam logic [4:0] STATE_OFF = 5'h02;
endpackage : ssr_pkg

/* shared/ssr_rd_if.sv */
// Interface carrying one register read between bank and read mux.
`timescale 1ns/100ps
interface ssr_rd_if;
  logic [7:0] addr;
  logic [15:0] data;
  modport bank (input addr, output data);
  modport mux (output addr, input data);
endinterface : ssr_rd_if

/* verilog/ssr_read_mux.sv */
// Registered read port; the primary and monitor ports each get their own instance.
`timescale 1ns/100ps
module ssr_read_mux
  import ssr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic rdEn,
  input wire logic [7:0] rdAddr,
  output logic [15:0] rdData,
  ssr_rd_if.mux bank
);
  logic [15:0] rdData_ff;

  assign bank.addr = rdAddr;
  assign rdData = rdData_ff;

  // Data holds between reads so a slow serial shifter can take it.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdData_ff <= 16'h0000;
    end else if (rdEn) begin
      rdData_ff <= bank.data;
    end
  end
endmodule : ssr_read_mux

/* verilog/ssr_status_bank.sv */
// System status register bank: revision, status flags, general status.
`timescale 1ns/100ps
// Functional notes
// RULE1: Read-only revision at 0x00: major [7:4], minor [3:0], upper byte zero.
// RULE2: Status flags set by hardware or by writing ones; zeros ignored.
// RULE3: Bit 15 set while any general fault bit is set.
// RULE4: Bit 14 set when dimming pulse reaches width limit.
// RULE5: Bit 13 set when mirror rail power-good timer expires.
// RULE6: Bit 12 set on primary port parity error in command or data.
// RULE7: Bit 11 is OR of all ADC block error flags.
// RULE8: Bits 10..8 checksum errors; bits 7 and 6 watchdog errors.
// RULE9: Bit 5 set whenever the top-level state changes.
// RULE10: Bit 4 set on excessive brightness fault.
// RULE11: Bit 3 set on mirror offset, reset or bias rail fault.
// RULE12: Bit 2 set at die temperature warning threshold.
// RULE13: Bit 1 set at die temperature error; always drives park output.
// RULE14: Bit 0 reads one while projector enable input is low.
// RULE15: General status [15:12] reports the clock ratio reading.
// RULE16: General status [7:5] records cause of last pass through off.
// RULE17: General status [4:0] shows current top-level state code.
// RULE18: General fault register read-only, resets to zero, ones are faults.
// RULE19: Monitor port only reads and must send complete transactions.
// RULE20: Status flags stay set until device reset.
module ssr_status_bank
  import ssr_pkg::*;
#(
  parameter logic [3:0] MAJOR_REV = 4'h1, // Arbitrary value.
  parameter logic [3:0] MINOR_REV = 4'h0  // Arbitrary value.
)
(
  input wire logic clk,
  input wire logic nrst,
  // Primary serial port register access.
  input wire logic priWrEn,
  input wire logic priRdEn,
  input wire logic [7:0] priAddr,
  input wire logic [15:0] priWrData,
  output logic [15:0] priRdData,
  // Monitor serial port, read only.
  input wire logic monRdEn,
  input wire logic [7:0] monAddr,
  output logic [15:0] monRdData,
  // Hardware event sources.
  input wire logic [15:0] generalFault,
  input wire logic dimmingPulseWidthLimit,
  input wire logic mirrorRailTimerExpired,
  input wire logic parityError,
  input wire logic [7:0] adcErrorFlags,
  input wire logic [2:0] checksumError,
  input wire logic watchdogTwoError,
  input wire logic watchdogOneError,
  input wire logic brightnessFault,
  input wire logic mirrorRailPowergoodFault,
  input wire logic tempWarning,
  input wire logic tempError,
  input wire logic projectorEnableInput,
  input wire logic [3:0] clockRatio,
  input wire logic [2:0] offCause,
  input wire logic [4:0] topState,
  output logic parkOutputN
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] status_ff;
  logic [15:0] nxt_status;
  logic [15:0] hwEvents;
  logic [4:0] topState_ff;
  logic [2:0] lastCause_ff;
  logic [15:0] fault_ff;
  logic stateSeen_ff;
  logic stateChanged;

  ssr_rd_if priIf ();
  ssr_rd_if monIf ();

  function automatic logic [15:0] readReg(input logic [7:0] addr,
                                          input logic [15:0] st,
                                          input logic [15:0] gs,
                                          input logic [15:0] gf);
    case (addr)
      ADDR_CHIP_REVISION: readReg = {8'h00, MAJOR_REV, MINOR_REV}; // RULE1
      ADDR_STATUS_FLAG_SET: readReg = st;
      ADDR_GENERAL_STATUS_ONE: readReg = gs;
      ADDR_GENERAL_FAULT: readReg = gf; // RULE18
      default: readReg = UNMAPPED_DATA;
    endcase
  endfunction : readReg

  // ----------------------------------------------------------------
  // Hardware event collection
  // ----------------------------------------------------------------
  assign stateChanged = stateSeen_ff && (topState != topState_ff); // RULE9

  always_comb begin
    hwEvents = 16'h0000;
    hwEvents[BIT_PG_FAULT] = |fault_ff; // RULE3
    hwEvents[BIT_DIM_LIMIT] = dimmingPulseWidthLimit; // RULE4
    hwEvents[BIT_RAIL_TIMER] = mirrorRailTimerExpired; // RULE5
    hwEvents[BIT_PARITY] = parityError; // RULE6
    hwEvents[BIT_ADC_ERR] = |adcErrorFlags; // RULE7
    hwEvents[BIT_CSUM_LED] = checksumError[2]; // RULE8
    hwEvents[BIT_CSUM_SENSOR] = checksumError[1]; // RULE8
    hwEvents[BIT_CSUM_ADC] = checksumError[0]; // RULE8
    hwEvents[BIT_WD_TWO] = watchdogTwoError; // RULE8
    hwEvents[BIT_WD_ONE] = watchdogOneError; // RULE8
    hwEvents[BIT_STATE_CHG] = stateChanged; // RULE9
    hwEvents[BIT_BRIGHT] = brightnessFault; // RULE10
    hwEvents[BIT_RAIL_FAULT] = mirrorRailPowergoodFault; // RULE11
    hwEvents[BIT_TEMP_WARN] = tempWarning; // RULE12
    hwEvents[BIT_TEMP_ERR] = tempError; // RULE13
    hwEvents[BIT_PROJ_LOW] = !projectorEnableInput; // RULE14
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Flags only accumulate; there is no clear path besides reset, so a
  // set and a clear can never collide.
  always_comb begin
    nxt_status = status_ff | hwEvents; // RULE20
    if (priWrEn && priAddr == ADDR_STATUS_FLAG_SET) begin
      nxt_status = nxt_status | priWrData; // RULE2
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      status_ff <= STATUS_RESET; // RULE2
    end else begin
      status_ff <= nxt_status; // RULE20
    end
  end

  // The park output follows the sticky flag; no mask sits in its path.
  assign parkOutputN = !status_ff[BIT_TEMP_ERR]; // RULE13

  // ----------------------------------------------------------------
  // General status and fault capture
  // ----------------------------------------------------------------
  // The first cycle after reset only records the state, so reset itself
  // is not reported as a change.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      topState_ff <= 5'h00;
      stateSeen_ff <= 1'b0;
    end else begin
      topState_ff <= topState; // RULE17
      stateSeen_ff <= 1'b1;
    end
  end

  // Cause is latched on entry into off so it survives later transitions.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lastCause_ff <= SSR_CAUSE_POR;
    end else if (topState == STATE_OFF && topState_ff != STATE_OFF) begin
      lastCause_ff <= offCause; // RULE16
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fault_ff <= FAULT_RESET; // RULE18
    end else begin
      fault_ff <= generalFault; // RULE18
    end
  end

  logic [15:0] generalStatus;
  logic [3:0] ratio_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ratio_ff <= GENERAL_RESET[15:12];
    end else begin
      ratio_ff <= clockRatio; // RULE15
    end
  end

  assign generalStatus = {ratio_ff, 4'h0, lastCause_ff, topState_ff}; // RULE17

  // ----------------------------------------------------------------
  // Read ports
  // ----------------------------------------------------------------
  assign priIf.data = readReg(priIf.addr, status_ff, generalStatus, fault_ff);
  // The monitor port has no write path at all.
  assign monIf.data = readReg(monIf.addr, status_ff, generalStatus, fault_ff); // RULE19

  ssr_read_mux uPriMux (
    .clk(clk),
    .nrst(nrst),
    .rdEn(priRdEn),
    .rdAddr(priAddr),
    .rdData(priRdData),
    .bank(priIf.mux)
  );

  ssr_read_mux uMonMux (
    .clk(clk),
    .nrst(nrst),
    .rdEn(monRdEn),
    .rdAddr(monAddr),
    .rdData(monRdData),
    .bank(monIf.mux)
  );
endmodule : ssr_status_bank

/* verification/ssr_status_bank_checker.sv */
// Concurrent checks on the ports of the status register bank.
`timescale 1ns/100ps
module ssr_status_bank_checker
  import ssr_pkg::*;
#(
  parameter logic [3:0] MAJOR_REV = 4'h1,
  parameter logic [3:0] MINOR_REV = 4'h0
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic priWrEn,
  input wire logic priRdEn,
  input wire logic [7:0] priAddr,
  input wire logic [15:0] priWrData,
  input wire logic [15:0] priRdData,
  input wire logic monRdEn,
  input wire logic [15:0] monRdData,
  input wire logic [15:0] generalFault,
  input wire logic tempError,
  input wire logic projectorEnableInput,
  input wire logic [3:0] clockRatio,
  input wire logic [4:0] topState,
  input wire logic parkOutputN
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic rdGs;
  assign rdGs = priRdEn && priAddr == ADDR_GENERAL_STATUS_ONE;
  property p_rev; priRdEn && priAddr == ADDR_CHIP_REVISION
    |=> priRdData == {8'h00, MAJOR_REV, MINOR_REV}; endproperty
  a_rev: assert property (p_rev) else $error("bad revision");
  property p_w1s; priWrEn && priAddr == ADDR_STATUS_FLAG_SET
    && priWrData[1] |=> !parkOutputN; endproperty
  a_w1s: assert property (p_w1s) else $error("set write lost");
  property p_park; tempError |=> !parkOutputN; endproperty
  a_park: assert property (p_park) else $error("park missed");
  property p_stick; !parkOutputN |=> !parkOutputN; endproperty
  a_stick: assert property (p_stick) else $error("flag cleared");
  // The registers load one edge after the inputs, hence depth two.
  property p_proj; priRdEn && priAddr == ADDR_STATUS_FLAG_SET && $past(nrst)
    && !$past(projectorEnableInput) |=> priRdData[0]; endproperty
  a_proj: assert property (p_proj) else $error("enable low lost");
  property p_gs; rdGs && $past(nrst) |=> priRdData[4:0] == $past(topState, 2)
    && priRdData[15:8] == {$past(clockRatio, 2), 4'h0}; endproperty
  a_gs: assert property (p_gs) else $error("bad status");
  property p_fault; priRdEn && priAddr == ADDR_GENERAL_FAULT && $past(nrst)
    |=> priRdData == $past(generalFault, 2); endproperty
  a_fault: assert property (p_fault) else $error("bad fault");
  property p_mon; !monRdEn |=> $stable(monRdData); endproperty
  a_mon: assert property (p_mon) else $error("monitor data moved");
endmodule : ssr_status_bank_checker

bind ssr_status_bank ssr_status_bank_checker #(
  .MAJOR_REV(MAJOR_REV), .MINOR_REV(MINOR_REV)
) u_chk (.clk, .nrst, .priWrEn, .priRdEn, .priAddr, .priWrData,
  .priRdData, .monRdEn, .monRdData, .generalFault, .tempError,
  .projectorEnableInput, .clockRatio, .topState, .parkOutputN);

/* verification/ssr_host_model.sv */
// Primary serial port master model issuing register accesses.
`timescale 1ns/100ps
module ssr_host_model (
  input wire logic clk,
  output logic priWrEn,
  output logic priRdEn,
  output logic [7:0] priAddr,
  output logic [15:0] priWrData,
  input wire logic [15:0] priRdData
);
  // ----------------------------------------------------------------
  // Accesses
  // ----------------------------------------------------------------
  initial begin
    priWrEn = 1'b0;
    priRdEn = 1'b0;
    priAddr = 8'h00;
    priWrData = 16'h0000;
  end
  // Idle address and data are inverted so a stale value never looks valid.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk); #1;
    priWrEn = 1'b1; priAddr = a; priWrData = d;
    @(posedge clk); #1;
    priWrEn = 1'b0; priAddr = ~a; priWrData = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk); #1;
    priRdEn = 1'b1; priAddr = a;
    @(posedge clk); #1;
    priRdEn = 1'b0; priAddr = ~a; d = priRdData;
  endtask : rd
endmodule : ssr_host_model

/* verification/ssr_status_bank_tb_top.sv */
// Self-checking bench for the status register bank.
`timescale 1ns/100ps
module ssr_status_bank_tb_top
  import ssr_pkg::*;
;
  logic clk, nrst, priWrEn, priRdEn, monRdEn, parkOutputN;
  logic [7:0] priAddr, monAddr;
  logic [15:0] priWrData, priRdData, monRdData, ev, gf;
  logic [3:0] cr;
  logic [2:0] oc;
  logic [4:0] ts;
  int n_errors = 0;
  int cmp_count = 0;
  // Each row: event inputs in the upper half, expected flags below.
  localparam logic [31:0] ROWS [10] = '{32'h0000_0000, 32'h8000_8000,
    32'h4000_4000, 32'h3000_3000, 32'h0800_0800, 32'h0700_0700,
    32'h00C0_00C0, 32'h0030_0030, 32'h000C_000C, 32'h0003_0003};
  ssr_status_bank #(.MAJOR_REV(4'hA), .MINOR_REV(4'h3)) u_dut (
    .clk, .nrst, .priWrEn, .priRdEn, .priAddr, .priWrData, .priRdData,
    .monRdEn, .monAddr, .monRdData, .generalFault(gf | {ev[15], 15'h0000}),
    .dimmingPulseWidthLimit(ev[14]), .mirrorRailTimerExpired(ev[13]),
    .parityError(ev[12]), .adcErrorFlags({ev[11], 7'h00}),
    .checksumError(ev[10:8]), .watchdogTwoError(ev[7]),
    .watchdogOneError(ev[6]), .brightnessFault(ev[4]),
    .mirrorRailPowergoodFault(ev[3]), .tempWarning(ev[2]),
    .tempError(ev[1]), .projectorEnableInput(!ev[0]), .clockRatio(cr),
    .offCause(oc), .topState(ev[5] ? 5'h11 : ts), .parkOutputN);
  ssr_host_model u_host (.clk, .priWrEn, .priRdEn, .priAddr, .priWrData,
    .priRdData);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic mrd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk); #1;
    monRdEn = 1'b1; monAddr = a;
    @(posedge clk); #1;
    monRdEn = 1'b0; monAddr = ~a; d = monRdData;
  endtask : mrd
  // Both ports read the same word in the same cycle.
  task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] p, m;
    fork u_host.rd(a, p); mrd(a, m); join
    check("primary", p, e);
    check("monitor", m, e);
  endtask : chk_rd
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run();
  end
  initial begin
    nrst = 1'b0; ev = 16'h0000; gf = 16'h0000; cr = 4'h0; oc = 3'h0;
    ts = 5'h00; monRdEn = 1'b0; monAddr = 8'h00;
    repeat (10) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk); #1;
      nrst = 1'b0; ev = 16'h0000;
      @(posedge clk); #1;
      // One settled cycle first, so the state-change row is a real change.
      nrst = 1'b1;
      @(posedge clk); #1;
      ev = ROWS[i][31:16];
      repeat (3) @(posedge clk);
      chk_rd(ADDR_STATUS_FLAG_SET, ROWS[i][15:0]);
      check("park", {15'h0, parkOutputN}, {15'h0, !ROWS[i][1]});
    end
    @(posedge clk); #1;
    nrst = 1'b0; ev = 16'h0000;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    chk_rd(ADDR_STATUS_FLAG_SET, STATUS_RESET);
    chk_rd(ADDR_GENERAL_FAULT, FAULT_RESET);
    chk_rd(8'h02, 16'h0000);
    check("park", {15'h0, parkOutputN}, 16'h0001);
    u_host.wr(ADDR_STATUS_FLAG_SET, 16'h0002);
    u_host.wr(ADDR_STATUS_FLAG_SET, 16'h0000);
    u_host.wr(ADDR_CHIP_REVISION, 16'hFFFF);
    chk_rd(ADDR_STATUS_FLAG_SET, 16'h0002);
    check("park", {15'h0, parkOutputN}, 16'h0000);
    chk_rd(ADDR_CHIP_REVISION, 16'h00A3);
    @(posedge clk); #1;
    nrst = 1'b0; gf = 16'h2001; cr = 4'h8;
    @(posedge clk); #1;
    nrst = 1'b1;
    repeat (3) @(posedge clk);
    chk_rd(ADDR_GENERAL_FAULT, 16'h2001);
    gf = 16'h0000;
    chk_rd(ADDR_GENERAL_FAULT, 16'h0000);
    chk_rd(ADDR_STATUS_FLAG_SET, 16'h8000);
    for (int c = 0; c < 6; c++) begin
      ts = 5'h08; oc = c[2:0];
      repeat (2) @(posedge clk);
      #1 ts = STATE_OFF;
      @(posedge clk); #1;
      oc = ~c[2:0]; ts = 5'h0D;
      repeat (2) @(posedge clk);
      chk_rd(ADDR_GENERAL_STATUS_ONE, {8'h80, c[2:0], 5'h0D});
    end
    complete_run();
  end
endmodule : ssr_status_bank_tb_top
